// ==== sdm_ctrl.sv ====
/*
 Supply drop monitor control with an AXI4-Lite slave.
 Assumes comparators synchronous to clk; instrRetire pulses per instruction.
*/
// Added by the designer: the AXI4-Lite slave port.
// What this block does
// RULE1: Request reset while enabled comparator reports supply below threshold.
// RULE2: Compare supply to warning threshold above drop threshold; may raise interrupt.
// RULE3: Run continuously or sample briefly once per fixed period.
// RULE4: Every reset reloads threshold, active mode and sleep mode from fuses.
// RULE5: Threshold and active mode ignore software writes; fuse copies only.
// RULE6: Sleep mode field resets from fuses and stays software writable.
// RULE7: Writing one to the interrupt enable bit enables the warning monitor.
// RULE8: Trigger select picks falling, rising or either-direction crossing.
// RULE9: Warning monitor stays inactive whenever the drop monitor is disabled.
// RULE10: In sampled mode the warning monitor evaluates only at sample instants.
// RULE11: With interrupt enabled, set flag on crossing in the selected direction.
// RULE12: Warning threshold follows the level-select field of warning control.
// RULE13: Warning interrupt is held off while the CPU is halted in debug.
// RULE14: Interrupt request equals enable AND flag, held until flag cleared.
// RULE15: Sleep entry uses sleep field mode; wake returns to active field mode.
// RULE16: Software writes unlock key, then sleep field within four instructions.
// RULE17: Sleep field write without valid unlock leaves the field unchanged.
// RULE18: Mode codes: 0 off, 1 continuous, 2 sampled, 3 continuous hold-wake.
// RULE19: Sample rate bit selects 1 kHz when clear, 125 Hz when set.
// RULE20: Level codes 0,1,2 give 5, 15, 25 percent above; others reserved.
// RULE21: Trigger codes 0 below, 1 above, 2 cross; others reserved.
// RULE22: Writing one clears the flag; zero no effect; set beats clear.
// RULE23: Status reads one while sampled supply is below warning threshold.
module sdm_ctrl #(
    parameter int FAST_CYC = sdm_pkg::FAST_SAMPLE_CYC,
    parameter int SLOW_CYC = sdm_pkg::SLOW_SAMPLE_CYC
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire sdm_pkg::sdm_fuse_t fuseCfg,
    input  wire sdm_pkg::sdm_cmp_t  cmpIn,
    input  wire logic              sleepDeep,
    input  wire logic              debugHalt,
    input  wire logic              instrRetire,
    output logic                   cmpEnable,
    output logic [2:0]             thresholdCode,
    output logic [1:0]             warnLevelSel,
    output logic                   brownoutReset,
    output logic                   wakeHold,
    output logic                   warnIrq,
    input  wire logic [5:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [5:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic       fuseLoad_ff;
    logic       sampleRate_ff;
    logic [1:0] activeMode_ff;
    logic [1:0] sleepMode_ff;
    logic [2:0] thresh_ff;
    logic [1:0] warnLevel_ff;
    logic [1:0] trigSel_ff;
    logic       irqEn_ff;
    logic       flag_ff;
    logic       below_ff;
    logic       belowValid_ff;
    logic [2:0] unlockCnt_ff;
    logic [31:0] divCnt_ff;
    logic [2:0] settleCnt_ff;
    logic       cmpReady_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave

    logic [5:0] awAddr_ff;
    logic       awHeld_ff;
    logic [31:0] wData_ff;
    logic [3:0] wStrb_ff;
    logic       wHeld_ff;

    function automatic logic [3:0] regIdx(input logic [5:0] addr);
        regIdx = addr[5:2];
    endfunction : regIdx

    wire        awTake   = s_axi_awvalid & s_axi_awready;
    wire        wTake    = s_axi_wvalid & s_axi_wready;
    wire        doWrite  = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
    wire [3:0]  wIdx     = regIdx(awAddr_ff);
    wire        lane0    = wStrb_ff[0];
    wire [7:0]  wByte    = wData_ff[7:0];
    wire        wrMode   = doWrite & lane0 & (wIdx == sdm_pkg::IDX_MODE_CTRL);
    wire        wrLevel  = doWrite & lane0 & (wIdx == sdm_pkg::IDX_WARN_LEVEL);
    wire        wrIntCtl = doWrite & lane0 & (wIdx == sdm_pkg::IDX_WARN_INTCTL);
    wire        wrFlags  = doWrite & lane0 & (wIdx == sdm_pkg::IDX_WARN_FLAGS);
    wire        wrKey    = doWrite & lane0 & (wIdx == sdm_pkg::IDX_CCP_KEY);
    wire        wMapped  = (wIdx <= sdm_pkg::IDX_THRESHOLD)
                         | ((wIdx >= sdm_pkg::IDX_WARN_LEVEL) & (wIdx <= sdm_pkg::IDX_CCP_KEY));
    wire        rdTake   = s_axi_arvalid & s_axi_arready;
    wire [3:0]  rIdx     = regIdx(s_axi_araddr);

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            awAddr_ff <= 6'h00;
            wData_ff  <= 32'h0000_0000;
            wStrb_ff  <= 4'h0;
        end else begin
            if (awTake) begin
                awHeld_ff <= 1'b1;
                awAddr_ff <= s_axi_awaddr;
            end else if (doWrite) begin
                awHeld_ff <= 1'b0;
            end
            if (wTake) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end else if (doWrite) begin
                wHeld_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'h0;
        end else begin
            s_axi_awready <= ~awHeld_ff & ~awTake & ~s_axi_bvalid & ~doWrite;
            s_axi_wready  <= ~wHeld_ff & ~wTake & ~s_axi_bvalid & ~doWrite;
            if (doWrite) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wMapped ? 2'h0 : 2'h2;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    logic [7:0] rByte;
    logic       rMapped;
    always_comb begin
        rByte   = 8'h00;
        rMapped = 1'b1;
        case (rIdx)
            sdm_pkg::IDX_MODE_CTRL:   rByte = {3'h0, sampleRate_ff, activeMode_ff, sleepMode_ff};
            sdm_pkg::IDX_THRESHOLD:   rByte = {5'h00, thresh_ff};
            sdm_pkg::IDX_WARN_LEVEL:  rByte = {6'h00, warnLevel_ff};
            sdm_pkg::IDX_WARN_INTCTL: rByte = {5'h00, trigSel_ff, irqEn_ff};
            sdm_pkg::IDX_WARN_FLAGS:  rByte = {7'h00, flag_ff};
            sdm_pkg::IDX_WARN_STATUS: rByte = {7'h00, below_ff};
            sdm_pkg::IDX_CCP_KEY:     rByte = 8'h00;
            default:                  rMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= 2'h0;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~rdTake;
            if (rdTake) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rByte};
                s_axi_rresp  <= rMapped ? 2'h0 : 2'h2;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Fuse load and protected sleep field

    // Fuses load on the first edge after release
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fuseLoad_ff   <= 1'b1;
            sampleRate_ff <= 1'b0;
            activeMode_ff <= sdm_pkg::MODE_DISABLED;
            sleepMode_ff  <= sdm_pkg::MODE_DISABLED;
            thresh_ff     <= 3'h0;
        end else begin
            fuseLoad_ff <= 1'b0;
            if (fuseLoad_ff) begin
                sampleRate_ff <= fuseCfg.sampleRate;     // RULE4
                activeMode_ff <= fuseCfg.activeMode;     // RULE4 RULE5
                sleepMode_ff  <= fuseCfg.sleepMode;      // RULE4 RULE6
                thresh_ff     <= fuseCfg.thresholdCode;  // RULE4 RULE5
            end else if (wrMode) begin
                sampleRate_ff <= wByte[sdm_pkg::POS_SAMPLE_RATE];
                if (unlockCnt_ff != 3'h0) begin
                    sleepMode_ff <= wByte[sdm_pkg::POS_SLEEP_MODE +: 2];  // RULE6 RULE17
                end
            end
        end
    end

    // Unlock window in retired instructions
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            unlockCnt_ff <= 3'h0;
        end else if (wrKey) begin
            unlockCnt_ff <= (wByte == sdm_pkg::IO_UNLOCK_KEY) ? 3'(sdm_pkg::UNLOCK_WINDOW) : 3'h0;  // RULE16
        end else if (wrMode) begin
            unlockCnt_ff <= 3'h0;
        end else if (instrRetire && unlockCnt_ff != 3'h0) begin
            unlockCnt_ff <= unlockCnt_ff - 3'h1;  // RULE16
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            warnLevel_ff <= sdm_pkg::RST_WARN_LEVEL;
            trigSel_ff   <= sdm_pkg::RST_TRIG_SEL;
            irqEn_ff     <= sdm_pkg::RST_IRQ_EN;
        end else begin
            if (wrLevel) begin
                warnLevel_ff <= wByte[1:0];  // RULE12 RULE20
            end
            if (wrIntCtl) begin
                irqEn_ff   <= wByte[sdm_pkg::POS_IRQ_ENABLE];     // RULE7
                trigSel_ff <= wByte[sdm_pkg::POS_TRIG_SEL +: 2];  // RULE8 RULE21
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode selection and sampling

    wire [1:0] curMode   = sleepDeep ? sleepMode_ff : activeMode_ff;  // RULE15
    wire       monOn     = ~fuseLoad_ff & (curMode == sdm_pkg::MODE_CONTINUOUS
                           | curMode == sdm_pkg::MODE_SAMPLED
                           | (curMode == sdm_pkg::MODE_CONT_WAKE & ~sleepDeep));  // RULE18
    wire       sampled   = curMode == sdm_pkg::MODE_SAMPLED;
    wire [31:0] period   = sampleRate_ff ? 32'(SLOW_CYC) : 32'(FAST_CYC);  // RULE19
    wire       tick      = divCnt_ff >= period - 32'h1;
    wire       settled   = settleCnt_ff == 3'(sdm_pkg::SETTLE_CYC);
    // Judge only a comparator powered last cycle
    wire       evalNow   = monOn & cmpReady_ff & (sampled ? settled : 1'b1);  // RULE3 RULE10
    wire       warnOn    = evalNow & irqEn_ff;                  // RULE9
    wire       inWindow  = settleCnt_ff != 3'h0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divCnt_ff    <= 32'h0;
            settleCnt_ff <= 3'h0;
            cmpReady_ff  <= 1'b0;
        end else begin
            cmpReady_ff <= cmpEnable;
            divCnt_ff <= (tick | ~sampled) ? 32'h0 : divCnt_ff + 32'h1;
            if (sampled & tick) begin
                settleCnt_ff <= 3'h1;  // RULE3
            end else if (inWindow & ~settled) begin
                settleCnt_ff <= settleCnt_ff + 3'h1;
            end else begin
                settleCnt_ff <= 3'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Warning detection, flag and outputs

    wire rise  = belowValid_ff & below_ff & ~cmpIn.warnBelow;
    wire fall  = belowValid_ff & ~below_ff & cmpIn.warnBelow;
    wire event_ = warnOn & ((trigSel_ff == sdm_pkg::TRIG_BELOW & fall)
                          | (trigSel_ff == sdm_pkg::TRIG_ABOVE & rise)
                          | (trigSel_ff == sdm_pkg::TRIG_CROSS & (rise | fall)));  // RULE8 RULE11

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            below_ff      <= 1'b0;
            belowValid_ff <= 1'b0;
            flag_ff       <= 1'b0;
        end else begin
            if (evalNow) begin
                below_ff      <= cmpIn.warnBelow;  // RULE23 RULE2
                belowValid_ff <= 1'b1;
            end else if (~monOn) begin
                belowValid_ff <= 1'b0;
            end
            if (event_) begin
                flag_ff <= 1'b1;  // RULE22
            end else if (wrFlags & wByte[0]) begin
                flag_ff <= 1'b0;  // RULE22
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cmpEnable     <= 1'b0;
            thresholdCode <= 3'h0;
            warnLevelSel  <= 2'h0;
            brownoutReset <= 1'b0;
            wakeHold      <= 1'b0;
            warnIrq       <= 1'b0;
        end else begin
            cmpEnable     <= monOn & (~sampled | inWindow);  // RULE3
            thresholdCode <= thresh_ff;
            warnLevelSel  <= warnLevel_ff;  // RULE12
            brownoutReset <= evalNow & cmpIn.dropBelow;  // RULE1
            wakeHold      <= ~fuseLoad_ff & activeMode_ff == sdm_pkg::MODE_CONT_WAKE & ~sleepDeep & ~belowValid_ff;  // RULE18
            warnIrq       <= irqEn_ff & (flag_ff | event_) & ~debugHalt;  // RULE14 RULE13
        end
    end

endmodule : sdm_ctrl

// ==== sdm_pkg.sv ====
/*
 Constants and carrier structs of the supply drop monitor control.
 Assumes a 32-bit register bus, one word per register.
*/
package sdm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_MODE_CTRL   = 4'h0;
    localparam logic [3:0] IDX_THRESHOLD   = 4'h1;
    localparam logic [3:0] IDX_WARN_LEVEL  = 4'h8;
    localparam logic [3:0] IDX_WARN_INTCTL = 4'h9;
    localparam logic [3:0] IDX_WARN_FLAGS  = 4'ha;
    localparam logic [3:0] IDX_WARN_STATUS = 4'hb;
    localparam logic [3:0] IDX_CCP_KEY     = 4'hc;
    localparam logic [3:0] IDX_SLEEP_CTRL  = 4'hd;

    // Field positions
    localparam int POS_SLEEP_MODE  = 0;
    localparam int POS_ACTIVE_MODE = 2;
    localparam int POS_SAMPLE_RATE = 4;
    localparam int POS_IRQ_ENABLE  = 0;
    localparam int POS_TRIG_SEL    = 1;

    // Reset values of software-owned fields
    localparam logic [1:0] RST_WARN_LEVEL = 2'h0;
    localparam logic [1:0] RST_TRIG_SEL   = 2'h0;
    localparam logic       RST_IRQ_EN     = 1'b0;

    // Operating-mode codes
    localparam logic [1:0] MODE_DISABLED   = 2'h0;
    localparam logic [1:0] MODE_CONTINUOUS = 2'h1;
    localparam logic [1:0] MODE_SAMPLED    = 2'h2;
    localparam logic [1:0] MODE_CONT_WAKE  = 2'h3;

    // Trigger-select codes
    localparam logic [1:0] TRIG_BELOW = 2'h0;
    localparam logic [1:0] TRIG_ABOVE = 2'h1;
    localparam logic [1:0] TRIG_CROSS = 2'h2;

    // Unlock key and window in CPU instructions
    localparam logic [7:0] IO_UNLOCK_KEY   = 8'hd8;
    localparam int         UNLOCK_WINDOW   = 4;

    // Timing
    localparam int CLK_HZ         = 200_000_000;
    localparam int FAST_SAMPLE_HZ = 1000;
    localparam int SLOW_SAMPLE_HZ = 125;
    localparam int FAST_SAMPLE_CYC = CLK_HZ / FAST_SAMPLE_HZ;
    localparam int SLOW_SAMPLE_CYC = CLK_HZ / SLOW_SAMPLE_HZ;
    localparam int SETTLE_CYC      = 4;

    // Fuse image
    typedef struct packed {
        logic       sampleRate;
        logic [1:0] activeMode;
        logic [1:0] sleepMode;
        logic [2:0] thresholdCode;
    } sdm_fuse_t;

    // Comparator outputs; high means supply below
    typedef struct packed {
        logic dropBelow;
        logic warnBelow;
    } sdm_cmp_t;

endpackage : sdm_pkg

// ==== sdm_ctrl_assertions.sv ====
/*
 Port-level checks for the supply drop monitor control block.
 Assumes fuseCfg changes only while sys_rst is high.
*/
module sdm_ctrl_assertions (
    input wire logic               clk,
    input wire logic               sys_rst,
    input wire sdm_pkg::sdm_fuse_t fuseCfg,
    input wire sdm_pkg::sdm_cmp_t  cmpIn,
    input wire logic               sleepDeep,
    input wire logic               debugHalt,
    input wire logic               cmpEnable,
    input wire logic [2:0]         thresholdCode,
    input wire logic               brownoutReset,
    input wire logic               wakeHold,
    input wire logic               warnIrq,
    input wire logic               s_axi_bvalid,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
////////////////////////////////////////
    a_thresh_fuse: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |-> thresholdCode == fuseCfg.thresholdCode)
        else $error("threshold code differs from fuse copy");
    a_brown_cause: assert property ($rose(brownoutReset) |-> $past(cmpEnable && cmpIn.dropBelow))
        else $error("reset request without an enabled low reading");
    a_off_quiet: assert property ((fuseCfg.activeMode == sdm_pkg::MODE_DISABLED && !sleepDeep)[*3]
        |-> !cmpEnable && !brownoutReset)
        else $error("disabled monitor still active");
    a_cont_on: assert property ((fuseCfg.activeMode == sdm_pkg::MODE_CONTINUOUS && !sleepDeep)[*3]
        |-> cmpEnable)
        else $error("continuous monitor not powered");
    a_sample_burst: assert property ($rose(cmpEnable) && fuseCfg.activeMode == sdm_pkg::MODE_SAMPLED && !sleepDeep
        |-> cmpEnable[*4] ##1 !cmpEnable)
        else $error("sample burst length wrong");
    a_debug_mask: assert property (debugHalt && $past(debugHalt) |-> !warnIrq)
        else $error("warning interrupt during debug halt");
    a_irq_release: assert property ($fell(warnIrq) |-> debugHalt || s_axi_bvalid || $past(s_axi_bvalid))
        else $error("warning interrupt dropped without a write");
    a_wake_hold: assert property (wakeHold |-> fuseCfg.activeMode == sdm_pkg::MODE_CONT_WAKE)
        else $error("execution hold outside hold-at-wake mode");
    a_read_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule : sdm_ctrl_assertions

bind sdm_ctrl sdm_ctrl_assertions u_chk (.clk, .sys_rst, .fuseCfg, .cmpIn, .sleepDeep, .debugHalt,
    .cmpEnable, .thresholdCode, .brownoutReset, .wakeHold, .warnIrq, .s_axi_bvalid, .s_axi_rdata,
    .s_axi_rvalid);

// ==== sdm_analog_model.sv ====
/*
 Behavioural stand-in for the analog supply comparators.
 Assumes the bench sets the supply level in millivolts.
*/
module sdm_analog_model #(
    parameter int BASE_MV = 1800, // Code 0 level; plain default
    parameter int STEP_MV = 400   // Spacing per code; plain default
) (
    input  wire logic         clk,
    input  wire logic         cmpEnable,
    input  wire logic [2:0]   thresholdCode,
    input  wire logic [1:0]   warnLevelSel,
    input  wire logic [15:0]  supplyMv,
    output sdm_pkg::sdm_cmp_t cmpIn
);
    timeunit 1ns;
    timeprecision 1ps;
    int dropMv;
    int warnMv;
    assign dropMv = BASE_MV + STEP_MV * int'(thresholdCode);
    assign warnMv = dropMv * (warnLevelSel == 2'h0 ? 105 : warnLevelSel == 2'h1 ? 115 : 125) / 100;
    initial cmpIn = '0;
    // Unpowered output toggles, so a design that trusts it is caught
    always @(posedge clk) begin
        if (cmpEnable) begin
            cmpIn <= {int'(supplyMv) < dropMv, int'(supplyMv) < warnMv};
        end else begin
            cmpIn <= ~cmpIn;
        end
    end
endmodule : sdm_analog_model

// ==== testbench.sv ====
/*
 Self-checking bench for the monitor control. Assumes the analog model.
*/
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int          FAST = 20;
    localparam int          SLOW = 160;
    localparam logic [15:0] HIGH_MV = 16'h1770; // Above every warning level
    localparam logic [15:0] MID_MV = 16'h073a;  // Between levels at code 0
    localparam logic [15:0] LOW_MV = 16'h03e8;  // Below drop level
    logic               clk, sys_rst, sleepDeep, debugHalt, instrRetire;
    sdm_pkg::sdm_fuse_t fuseCfg, f;
    sdm_pkg::sdm_cmp_t  cmpIn;
    logic               cmpEnable, brownoutReset, wakeHold, warnIrq, samp, prev;
    logic [2:0]         thresholdCode;
    logic [1:0]         warnLevelSel, s_axi_bresp, s_axi_rresp, rsp, slp, nslp, lvl;
    logic [5:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]        s_axi_wdata, s_axi_rdata, seed, rd;
    logic [3:0]         s_axi_wstrb;
    logic               s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic               s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [15:0]        supplyMv;
    int                 errors, comparisons, cnt, ex;

    sdm_ctrl #(.FAST_CYC(FAST), .SLOW_CYC(SLOW)) dut (.*);
    sdm_analog_model model (.*);

    always #2.5 clk = ~clk;
////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [7:0] modeWord(input logic sr, input logic [1:0] act, input logic [1:0] sl);
        return {3'h0, sr, act, sl};
    endfunction : modeWord
    function automatic logic [31:0] flagExp(input logic [1:0] trig, input logic falling);
        return {31'h0, trig == sdm_pkg::TRIG_CROSS || (trig == sdm_pkg::TRIG_BELOW) == falling};
    endfunction : flagExp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic end_sim;
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    task automatic axiWrite(input logic [3:0] idx, input logic [7:0] val);
        logic aw, w, b;
        b = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {seed[31:8], val};
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b) begin
            @(negedge clk);
            aw = s_axi_awvalid && s_axi_awready;
            w = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge clk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        @(negedge clk);
    endtask : axiWrite
    task automatic axiRead(input logic [3:0] idx);
        logic ar, r;
        r = 1'b0;
        @(posedge clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r) begin
            @(negedge clk);
            ar = s_axi_arvalid && s_axi_arready;
            r = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk);
            if (ar) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
    endtask : axiRead
    task automatic doReset(input logic [7:0] fz);
        @(posedge clk);
        sys_rst <= 1'b1;
        fuseCfg <= fz;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : doReset
    task automatic retire(input int n);
        repeat (n) begin
            @(posedge clk);
            instrRetire <= 1'b1;
            @(posedge clk);
            instrRetire <= 1'b0;
        end
    endtask : retire
////////////////////////////////////////
    initial begin
        {clk, sleepDeep, debugHalt, instrRetire, fuseCfg, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, s_axi_wstrb, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {errors, comparisons} = '0;
        sys_rst = 1'b1;
        supplyMv = HIGH_MV;
        seed = 32'h2625d5ba;
        for (int i = 0; i < 3; i++) begin
            seed = lfsr(seed);
            f = (i == 0) ? 8'h38 : seed[7:0];
            doReset(f);
            axiRead(sdm_pkg::IDX_MODE_CTRL);
            check(rd, {24'h0, modeWord(f.sampleRate, f.activeMode, f.sleepMode)});
            for (int j = 8; j < 12; j++) begin
                axiRead(4'(j));
                check(rd, 32'h0);
            end
            axiWrite(sdm_pkg::IDX_THRESHOLD, 8'hff);
            axiRead(sdm_pkg::IDX_THRESHOLD);
            check(rd, {29'h0, f.thresholdCode});
            samp = ~f.sampleRate;
            slp = f.sleepMode;
            axiWrite(sdm_pkg::IDX_MODE_CTRL, ~modeWord(f.sampleRate, f.activeMode, f.sleepMode));
            for (int k = 3; k <= 4; k++) begin
                axiRead(sdm_pkg::IDX_MODE_CTRL);
                check(rd, {24'h0, modeWord(samp, f.activeMode, slp)});
                axiWrite(sdm_pkg::IDX_CCP_KEY, sdm_pkg::IO_UNLOCK_KEY);
                retire(k);
                nslp = slp + 2'h1;
                axiWrite(sdm_pkg::IDX_MODE_CTRL, modeWord(samp, f.activeMode, nslp));
                if (k == 3) slp = nslp;
            end
            axiRead(sdm_pkg::IDX_MODE_CTRL);
            check(rd, {24'h0, modeWord(samp, f.activeMode, slp)});
        end
        axiRead(4'h2);
        check(32'(rsp), 32'h2);
        axiWrite(sdm_pkg::IDX_SLEEP_CTRL, 8'hff);
        check(32'(rsp), 32'h2);
        // Warning monitor, continuous mode, drop code 0
        doReset(8'h20);
        seed = lfsr(seed);
        lvl = 2'(seed[7:0] % 3);
        axiWrite(sdm_pkg::IDX_WARN_LEVEL, {6'h0, lvl});
        check(32'(warnLevelSel), 32'(lvl));
        for (int t = 0; t < 3; t++) begin
            axiWrite(sdm_pkg::IDX_WARN_INTCTL, 8'(t * 2 + 1));
            repeat (10) @(posedge clk);
            supplyMv <= MID_MV;
            repeat (10) @(posedge clk);
            axiRead(sdm_pkg::IDX_WARN_STATUS);
            check(rd, 32'h1);
            axiRead(sdm_pkg::IDX_WARN_FLAGS);
            check(rd, flagExp(t[1:0], 1'b1));
            check(32'(warnIrq), flagExp(t[1:0], 1'b1));
            debugHalt <= 1'b1;
            repeat (3) @(posedge clk);
            check(32'(warnIrq), 32'h0);
            debugHalt <= 1'b0;
            axiWrite(sdm_pkg::IDX_WARN_FLAGS, 8'h0);
            axiRead(sdm_pkg::IDX_WARN_FLAGS);
            check(rd, flagExp(t[1:0], 1'b1));
            axiWrite(sdm_pkg::IDX_WARN_FLAGS, 8'h1);
            check(32'(warnIrq), 32'h0);
            supplyMv <= HIGH_MV;
            repeat (10) @(posedge clk);
            axiRead(sdm_pkg::IDX_WARN_FLAGS);
            check(rd, flagExp(t[1:0], 1'b0));
            axiWrite(sdm_pkg::IDX_WARN_FLAGS, 8'h1);
        end
        supplyMv <= LOW_MV;
        repeat (10) @(posedge clk);
        check(32'(brownoutReset), 32'h1);
        supplyMv <= HIGH_MV;
        sleepDeep <= 1'b1;
        repeat (10) @(posedge clk);
        check({cmpEnable, brownoutReset}, 32'h0);
        sleepDeep <= 1'b0;
        repeat (10) @(posedge clk);
        check(32'(cmpEnable), 32'h1);
        // Disabled monitor ignores a deep drop
        doReset(8'h00);
        axiWrite(sdm_pkg::IDX_WARN_INTCTL, 8'h5);
        supplyMv <= LOW_MV;
        repeat (20) @(posedge clk);
        axiRead(sdm_pkg::IDX_WARN_FLAGS);
        check({rd[0], brownoutReset, cmpEnable}, 32'h0);
        supplyMv <= HIGH_MV;
        // Sampled mode at both rates
        doReset(8'h40);
        for (int s = 0; s < 2; s++) begin
            axiWrite(sdm_pkg::IDX_MODE_CTRL, modeWord(s[0], 2'h2, 2'h0));
            cnt = 0;
            prev = cmpEnable;
            repeat (320) begin
                @(posedge clk);
                #1;
                if (cmpEnable && !prev) cnt++;
                prev = cmpEnable;
            end
            ex = 320 / (s == 1 ? SLOW : FAST);
            check(32'(cnt >= ex - 1 && cnt <= ex + 1), 32'h1);
        end
        end_sim();
    end

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        end_sim();
    end
endmodule : testbench
